// [wdog_regs.vh]
// Purpose: constants shared by the watchdog timer and its helpers
// Assumes: 8-bit write data from the processor core
// Notes: definitions only, no logic
`ifndef WDOG_REGS_VH
`define WDOG_REGS_VH

// service key bytes written to the reset status address
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA

// option register one: timeout select field
`define TSEL_HI 7
`define TSEL_LO 6
`define TSEL_W 2
`define TSEL_OFF 2'h0
`define TSEL_SHORT 2'h1
`define TSEL_MID 2'h2
`define TSEL_LONG 2'h3
`define TSEL_RESET 2'h3

// option register two: count clock select and window enable bits
`define CLKS_BIT 7
`define WIN_BIT 6
`define CLKS_LPO 1'h0
`define CLKS_BUS 1'h1
`define CLKS_RESET 1'h0
`define WIN_RESET 1'h0

// counter width and timeout lengths in count cycles
`define CNT_W 18
`define CNT_ZERO 18'h00000
`define CNT_ONE 18'h00001
`define LPO_TO_SHORT 18'h00020
`define LPO_TO_MID 18'h00100
`define LPO_TO_LONG 18'h00400
`define BUS_TO_SHORT 18'h02000
`define BUS_TO_MID 18'h10000
`define BUS_TO_LONG 18'h3FFFF

// window opens when a quarter of the period remains
`define WIN_SHIFT 2

// service sequence states
`define SEQ_IDLE 1'h0
`define SEQ_GOT_FIRST 1'h1

`endif

// [lpo_tick_sync.v]
// Purpose: bring the free running 1 kHz source into the bus clock domain
// Assumes: source is much slower than clk
// Notes: emits a one-cycle pulse per rising edge of the source
`timescale 1ns/100ps
`default_nettype none

module lpo_tick_sync (
    input wire clk, // bus clock
    input wire rst, // asynchronous reset, active high
    input wire lpo_in, // raw 1 kHz source from the other clock
    output reg tick // one pulse per rising edge of lpo_in
);

// edges are ignored until the chain holds real samples after reset
localparam [1:0] FILL_DONE = 2'h3;

reg meta_reg;
reg sync_reg;
reg last_reg;
reg [1:0] fill_reg;

// first flop feeds only the second
always @(posedge clk or posedge rst) begin
    if (rst) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        last_reg <= 1'b0;
        fill_reg <= 2'h0;
        tick <= 1'b0;
    end else begin
        meta_reg <= lpo_in;
        sync_reg <= meta_reg;
        last_reg <= sync_reg;
        if (fill_reg != FILL_DONE) begin
            fill_reg <= fill_reg + 2'h1;
        end
        // no false edge when the source is already high at release
        tick <= sync_reg & ~last_reg & (fill_reg == FILL_DONE);
    end
end

endmodule // lpo_tick_sync

`default_nettype wire

// [wdog_timer.v]
// Purpose: watchdog timer that requests a system reset when not serviced
// Assumes: rst is asserted by the system for any reset, including ours;
//          write strobes and mode levels come from logic on clk
// Notes: option registers are write-once until the next reset
//
// How it works
// - after any reset the watchdog runs, enabled, with no software action
// - timeout select of zero in option register one stops the count, timeout and window checks; bad bytes still reset
// - writing 0x55 then 0xAA to reset status restarts the timeout
// - reset status writes never change the status contents, only the watchdog
// - missing the service before timeout requests a system reset
// - any other byte written to reset status requests reset at once
// - clock select in option register two picks bus or 1 kHz count clock
// - timeout select gives three lengths for each count clock
// - default is the 1 kHz clock with the longest, 2^10 cycle timeout
// - bus clock with window enable accepts service only in final quarter
// - in windowed mode an early service write requests reset at once
// - window mode is ignored while the 1 kHz clock is selected
// - counter clears on first write to each option register and on reset
// - later option writes are ignored until the next reset
// - bus clock counter holds in debug or stop and resumes after
// - 1 kHz counter clears on debug or stop entry, restarts from zero
// - a watchdog reset sets its own cause bit in reset status
`timescale 1ns/100ps
`default_nettype none
`include "wdog_regs.vh"

module wdog_timer #(
    parameter [17:0] LPO_SHORT = `LPO_TO_SHORT, // 1 kHz shortest timeout
    parameter [17:0] LPO_MID = `LPO_TO_MID, // 1 kHz middle timeout
    parameter [17:0] LPO_LONG = `LPO_TO_LONG, // 1 kHz longest timeout
    parameter [17:0] BUS_SHORT = `BUS_TO_SHORT, // bus shortest timeout
    parameter [17:0] BUS_MID = `BUS_TO_MID, // bus middle timeout
    parameter [17:0] BUS_LONG = `BUS_TO_LONG // bus longest timeout
) (
    input wire clk, // bus clock, 10 MHz
    input wire rst, // any system reset, asynchronous, active high
    input wire por_rst, // power-on reset, asynchronous, active high
    input wire other_reset_evt, // pulse: non-watchdog reset source fired
    input wire lpo_clk_in, // free running 1 kHz source
    input wire [7:0] wr_data, // processor write data
    input wire status_wr, // pulse: write to reset status address
    input wire opt_one_wr, // pulse: write to option register one
    input wire opt_two_wr, // pulse: write to option register two
    input wire stop_mode, // level: system in stop mode
    input wire debug_mode, // level: background debug mode active
    output reg wdog_reset_req, // level: system reset request
    output reg wdog_cause, // reset status cause bit for the watchdog
    output reg [1:0] timeout_select, // active timeout select field
    output reg count_clock_select, // 1 selects bus clock, 0 the 1 kHz
    output reg window_enable, // window enable as stored
    output reg opt_one_locked, // option register one has been written
    output reg opt_two_locked, // option register two has been written
    output reg window_open, // service currently accepted in window mode
    output reg [17:0] count_value // present watchdog count
);

// 1 kHz edge pulse in the bus clock domain
wire lpo_tick;

lpo_tick_sync u_lpo_sync (
    .clk(clk),
    .rst(rst),
    .lpo_in(lpo_clk_in),
    .tick(lpo_tick)
);

// sequence state
reg seq_reg;
reg seq_next;

// combinational helpers
reg [17:0] bus_limit;
reg [17:0] lpo_limit;
reg [17:0] limit;
reg [17:0] win_start;
reg [17:0] count_next;
reg count_evt;
reg enabled;
reg windowed;
reg in_window;
reg good_byte;
reg early_write;
reg bad_write;
reg service_done;
reg timed_out;
reg fire;
reg held_mode;
reg opt_init;
reg window_next;
reg req_next;
reg cause_next;
reg [1:0] tsel_next;
reg lock_one_next;
reg clks_next;
reg win_en_next;
reg lock_two_next;

// bus clock timeout for the present select field
always @* begin
    case (timeout_select)
        `TSEL_SHORT: begin
            bus_limit = BUS_SHORT;
        end
        `TSEL_MID: begin
            bus_limit = BUS_MID;
        end
        `TSEL_LONG: begin
            bus_limit = BUS_LONG;
        end
        default: begin
            bus_limit = BUS_LONG;
        end
    endcase
end

// 1 kHz timeout for the present select field
always @* begin
    case (timeout_select)
        `TSEL_SHORT: begin
            lpo_limit = LPO_SHORT;
        end
        `TSEL_MID: begin
            lpo_limit = LPO_MID;
        end
        `TSEL_LONG: begin
            lpo_limit = LPO_LONG;
        end
        default: begin
            lpo_limit = LPO_LONG;
        end
    endcase
end

// selected timeout length for the present count clock
always @* begin
    if (count_clock_select == `CLKS_BUS) begin
        limit = bus_limit;
    end else begin
        limit = lpo_limit;
    end
end

// enable and window boundary
always @* begin
    enabled = (timeout_select != `TSEL_OFF);
    win_start = limit - (limit >> `WIN_SHIFT);
    // window only exists on the bus clock
    windowed = enabled && window_enable &&
        (count_clock_select == `CLKS_BUS);
    in_window = (count_value >= win_start);
end

// classify a write to the reset status address
always @* begin
    good_byte = (wr_data == `KEY_FIRST) || (wr_data == `KEY_SECOND);
    bad_write = status_wr && !good_byte;
    early_write = status_wr && good_byte && windowed &&
        !in_window;
    service_done = status_wr && (wr_data == `KEY_SECOND) &&
        (seq_reg == `SEQ_GOT_FIRST) && !early_write;
end

// service sequence: 0x55 arms, 0xAA completes
always @* begin
    seq_next = seq_reg;
    if (status_wr) begin
        case (seq_reg)
            `SEQ_IDLE: begin
                if (wr_data == `KEY_FIRST) begin
                    seq_next = `SEQ_GOT_FIRST;
                end
            end
            `SEQ_GOT_FIRST: begin
                if (wr_data == `KEY_SECOND) begin
                    seq_next = `SEQ_IDLE;
                end else if (wr_data != `KEY_FIRST) begin
                    seq_next = `SEQ_IDLE;
                end
            end
            default: seq_next = `SEQ_IDLE;
        endcase
    end
end

// count event, low power mode handling and timeout
always @* begin
    held_mode = stop_mode || debug_mode;
    opt_init = (opt_one_wr && !opt_one_locked) ||
        (opt_two_wr && !opt_two_locked);
    if (count_clock_select == `CLKS_BUS) begin
        count_evt = enabled && !held_mode;
    end else begin
        count_evt = enabled && !held_mode && lpo_tick;
    end
    timed_out = count_evt && (count_value == limit - `CNT_ONE);
    fire = timed_out || bad_write || early_write;
end

// next counter value
always @* begin
    count_next = count_value;
    if (opt_init || service_done || !enabled) begin
        count_next = `CNT_ZERO;
    end else if (held_mode &&
            count_clock_select == `CLKS_LPO) begin
        // 1 kHz counter stays cleared throughout the mode
        count_next = `CNT_ZERO;
    end else if (count_evt) begin
        count_next = count_value + `CNT_ONE;
    end
end

// window flag follows the counter value being loaded
always @* begin
    window_next = windowed && (count_next >= win_start);
end

// request holds until the system reset takes it down
always @* begin
    req_next = wdog_reset_req;
    if (fire) begin
        req_next = 1'b1;
    end
end

// counter and sequence
always @(posedge clk or posedge rst) begin
    if (rst) begin
        count_value <= `CNT_ZERO;
        seq_reg <= `SEQ_IDLE;
    end else begin
        count_value <= count_next;
        seq_reg <= seq_next;
    end
end

// window flag and reset request
always @(posedge clk or posedge rst) begin
    if (rst) begin
        window_open <= 1'b0;
        wdog_reset_req <= 1'b0;
    end else begin
        window_open <= window_next;
        wdog_reset_req <= req_next;
    end
end

// option register one takes only its first write
always @* begin
    tsel_next = timeout_select;
    lock_one_next = opt_one_locked;
    if (opt_one_wr && !opt_one_locked) begin
        tsel_next = wr_data[`TSEL_HI:`TSEL_LO];
        lock_one_next = 1'b1;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        timeout_select <= `TSEL_RESET;
        opt_one_locked <= 1'b0;
    end else begin
        timeout_select <= tsel_next;
        opt_one_locked <= lock_one_next;
    end
end

// option register two takes only its first write
always @* begin
    clks_next = count_clock_select;
    win_en_next = window_enable;
    lock_two_next = opt_two_locked;
    if (opt_two_wr && !opt_two_locked) begin
        clks_next = wr_data[`CLKS_BIT];
        win_en_next = wr_data[`WIN_BIT];
        lock_two_next = 1'b1;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        count_clock_select <= `CLKS_RESET;
        window_enable <= `WIN_RESET;
        opt_two_locked <= 1'b0;
    end else begin
        count_clock_select <= clks_next;
        window_enable <= win_en_next;
        opt_two_locked <= lock_two_next;
    end
end

// cause bit: a fire sets it and wins over a clear from another source
always @* begin
    cause_next = wdog_cause;
    if (fire && !rst) begin
        cause_next = 1'b1;
    end else if (other_reset_evt) begin
        cause_next = 1'b0;
    end
end

// cause bit survives the reset it causes; status writes leave it alone
always @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
        wdog_cause <= 1'b0;
    end else begin
        wdog_cause <= cause_next;
    end
end

endmodule // wdog_timer

`default_nettype wire

// [wdog_timer_assertions.sv]
// Purpose: port level property checks for wdog_timer
// Assumes: bus timeout parameters match the bound instance
// Notes: bound to every wdog_timer instance
`timescale 1ns/100ps
`default_nettype none
module wdog_timer_chk #(
    parameter [17:0] BUS_SHORT = 18'h00010, // bus shortest timeout
    parameter [17:0] BUS_MID = 18'h00020, // bus middle timeout
    parameter [17:0] BUS_LONG = 18'h00040 // bus longest timeout
) (
    input wire clk, // clock
    input wire rst, // any reset
    input wire por_rst, // power-on reset
    input wire [7:0] wr_data, // write data
    input wire status_wr, // status write
    input wire opt_one_wr, // option one write
    input wire opt_two_wr, // option two write
    input wire stop_mode, // stop level
    input wire debug_mode, // debug level
    input wire wdog_reset_req, // reset request
    input wire wdog_cause, // cause bit
    input wire [1:0] timeout_select, // timeout field
    input wire count_clock_select, // 1 is bus clock
    input wire window_enable, // window bit
    input wire opt_one_locked, // option one written
    input wire opt_two_locked, // option two written
    input wire window_open, // window flag
    input wire [17:0] count_value // counter
);
    wire bus = count_clock_select;
    wire [1:0] wr_tsel = wr_data[7:6];
    wire [17:0] lim = timeout_select == 2'h1 ? BUS_SHORT :
        timeout_select == 2'h2 ? BUS_MID : BUS_LONG;
    wire key = wr_data == 8'h55 || wr_data == 8'hAA;
    wire quiet = !status_wr && !opt_one_wr && !opt_two_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    bad_key_a: assert property (status_wr && !key |=> wdog_reset_req)
        else $error("bad byte gave no reset");
    key_svc_a: assert property (status_wr && wr_data == 8'h55 ##1
        !status_wr ##1 status_wr && wr_data == 8'hAA && !wdog_reset_req &&
        !(bus && window_enable) |=> count_value == 18'h00000)
        else $error("service did not clear count");
    req_holds_a: assert property (wdog_reset_req |=> wdog_reset_req)
        else $error("reset request dropped");
    bus_timeout_a: assert property (bus && timeout_select != 2'h0 &&
        count_value == lim - 18'h00001 && quiet && !stop_mode &&
        !debug_mode |=> wdog_reset_req)
        else $error("no reset at timeout");
    early_svc_a: assert property (bus && window_enable && status_wr &&
        key && timeout_select != 2'h0 &&
        count_value < lim - (lim >> 2) |=> wdog_reset_req)
        else $error("early service accepted");
    lpo_nowin_a: assert property (!bus |-> !window_open)
        else $error("window open on slow clock");
    bus_freeze_a: assert property (bus && (stop_mode || debug_mode) &&
        quiet |=> $stable(count_value))
        else $error("bus count moved while held");
    lpo_clear_a: assert property (!bus && (stop_mode || debug_mode)
        |=> count_value == 18'h00000)
        else $error("slow count not cleared");
    tsel_lock_a: assert property (opt_one_locked |=> $stable(timeout_select))
        else $error("locked timeout changed");
    first_wr_a: assert property (opt_one_wr && !opt_one_locked |=>
        count_value == 18'h00000 && timeout_select == $past(wr_tsel))
        else $error("first option write wrong");
    dflt_tsel_a: assert property (!opt_one_locked |-> timeout_select == 2'h3)
        else $error("default timeout wrong");
    dflt_clk_a: assert property (!opt_two_locked |-> !bus && !window_enable)
        else $error("default clock wrong");
    cause_set_a: assert property (disable iff (rst || por_rst)
        $rose(wdog_reset_req) |-> ##[0:1] wdog_cause)
        else $error("cause bit not set");
    cover property (status_wr && wr_data == 8'hAA && count_value == 18'h0);
    cover property (bus && $rose(wdog_reset_req));
    cover property (window_open && status_wr && !wdog_reset_req);
endmodule // wdog_timer_chk

bind wdog_timer wdog_timer_chk #(.BUS_SHORT(BUS_SHORT), .BUS_MID(BUS_MID),
    .BUS_LONG(BUS_LONG)) i_chk (.clk(clk), .rst(rst), .por_rst(por_rst),
    .wr_data(wr_data), .status_wr(status_wr), .opt_one_wr(opt_one_wr),
    .opt_two_wr(opt_two_wr), .stop_mode(stop_mode), .debug_mode(debug_mode),
    .wdog_reset_req(wdog_reset_req), .wdog_cause(wdog_cause),
    .timeout_select(timeout_select), .count_clock_select(count_clock_select),
    .window_enable(window_enable), .opt_one_locked(opt_one_locked),
    .opt_two_locked(opt_two_locked), .window_open(window_open),
    .count_value(count_value));
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for wdog_timer
// Assumes: short timeouts, slow source sped up to keep the run short
// Notes: each write-once case starts from a fresh reset
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk, lpo, wdog_reset_req, wdog_cause, count_clock_select;
    logic rst, por_rst, oth;
    logic stop_mode, debug_mode, window_enable;
    logic opt_one_locked, opt_two_locked, window_open;
    logic [7:0] wr_data, d;
    logic [2:0] stb = 3'h0;
    logic [1:0] timeout_select;
    logic [17:0] count_value;
    logic [31:0] seed = 32'h00007B52;
    int errors = 0, n_tests = 0, n, i;

    wdog_timer #(.LPO_SHORT(18'h4), .LPO_MID(18'h8), .LPO_LONG(18'h10),
        .BUS_SHORT(18'h10), .BUS_MID(18'h20), .BUS_LONG(18'h40)) i_dut (
        .clk(clk), .rst(rst), .por_rst(por_rst), .other_reset_evt(oth),
        .lpo_clk_in(lpo), .wr_data(wr_data), .status_wr(stb[0]),
        .opt_one_wr(stb[1]), .opt_two_wr(stb[2]), .stop_mode(stop_mode),
        .debug_mode(debug_mode), .wdog_reset_req(wdog_reset_req),
        .wdog_cause(wdog_cause), .timeout_select(timeout_select),
        .count_clock_select(count_clock_select),
        .window_enable(window_enable), .opt_one_locked(opt_one_locked),
        .opt_two_locked(opt_two_locked), .window_open(window_open),
        .count_value(count_value));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // slow source at an unrelated phase
    initial begin
        lpo = 1'h0;
        forever #1037 lpo = ~lpo;
    end
    initial begin
        #4000000;
        errors++;
        results;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task results;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input string s, input logic [17:0] e, input logic [17:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task rs;
        rst <= 1'h1;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        por_rst <= 1'h0;
    endtask
    task wr(input int k, input logic [7:0] v);
        @(posedge clk);
        stb[k] <= 1'h1;
        wr_data <= v;
        @(posedge clk);
        stb <= 3'h0;
    endtask
    task cfg(input logic [7:0] a, input logic [7:0] b);
        rs;
        wr(1, a);
        wr(2, b);
    endtask
    task wait_req(output int c);
        c = 0;
        while (wdog_reset_req !== 1'h1 && c < 1000) begin
            @(negedge clk);
            c++;
        end
    endtask

    initial begin
        rst <= 1'h1;
        por_rst <= 1'h1;
        oth <= 1'h0;
        stop_mode <= 1'h0;
        debug_mode <= 1'h0;
        wr_data <= 8'h00;
        @(posedge clk);
        for (i = 0; i < 4; i++) begin
            rs;
            d = (i == 0) ? 8'h54 : 8'(rnd());
            if (d == 8'h55 || d == 8'hAA) d = 8'h00;
            wr(0, d);
            repeat (2) @(negedge clk);
            chk("bad_req", 1'h1, wdog_reset_req);
            chk("bad_cause", 1'h1, wdog_cause);
        end
        rs;
        @(negedge clk);
        chk("cause_kept", 1'h1, wdog_cause);
        chk("dflt_tsel", 2'h3, timeout_select);
        chk("dflt_clks", 1'h0, count_clock_select);
        chk("dflt_lock1", 1'h0, opt_one_locked);
        chk("dflt_lock2", 1'h0, opt_two_locked);
        @(posedge clk);
        oth <= 1'h1;
        @(posedge clk);
        oth <= 1'h0;
        n = rnd() % 100;
        repeat (n) @(posedge clk);
        wr(0, 8'h55);
        wr(0, 8'hAA);
        @(negedge clk);
        chk("cause_clr", 1'h0, wdog_cause);
        chk("svc_cnt", 18'h0, count_value);
        chk("svc_req", 1'h0, wdog_reset_req);
        wait_req(n);
        chk("lpo_to", 1'h1, n > 300 && n < 380);
        for (i = 1; i < 4; i++) begin
            cfg(8'(i << 6), 8'h80);
            d = 8'(16 << (i - 1));
            wait_req(n);
            chk("bus_to", 1'h1, n >= d && n <= d + 2);
        end
        cfg(8'h00, 8'h80);
        repeat (100) @(posedge clk);
        wr(1, 8'hC0);
        wr(2, 8'h40);
        @(negedge clk);
        chk("off_req", 1'h0, wdog_reset_req);
        chk("lock_tsel", 2'h0, timeout_select);
        chk("lock_win", 1'h0, window_enable);
        chk("lock_one", 1'h1, opt_one_locked);
        chk("lock_two", 1'h1, opt_two_locked);
        cfg(8'h80, 8'hC0);
        @(negedge clk);
        chk("win_shut", 1'h0, window_open);
        wr(0, 8'h55);
        @(negedge clk);
        chk("early", 1'h1, wdog_reset_req);
        cfg(8'h80, 8'hC0);
        repeat (24) @(posedge clk);
        @(negedge clk);
        chk("win_open", 1'h1, window_open);
        wr(0, 8'h55);
        wr(0, 8'hAA);
        @(negedge clk);
        chk("win_req", 1'h0, wdog_reset_req);
        chk("win_cnt", 18'h0, count_value);
        cfg(8'hC0, 8'h40);
        wr(0, 8'h55);
        wr(0, 8'hAA);
        @(negedge clk);
        chk("lpo_win", 1'h0, wdog_reset_req);
        chk("lpo_wopen", 1'h0, window_open);
        cfg(8'hC0, 8'h80);
        repeat (10) @(posedge clk);
        stop_mode <= 1'h1;
        @(negedge clk);
        d = 8'(count_value);
        repeat (20) @(posedge clk);
        stop_mode <= 1'h0;
        @(negedge clk);
        chk("hold", d, count_value);
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("resume", d + 8'h05, count_value);
        cfg(8'hC0, 8'h00);
        repeat (60) @(posedge clk);
        chk("lpo_run", 1'h1, count_value != 18'h0);
        @(posedge clk);
        debug_mode <= 1'h1;
        repeat (30) @(posedge clk);
        @(negedge clk);
        chk("lpo_clr", 18'h0, count_value);
        results;
    end
endmodule // tb_top
`default_nettype wire
